// ### verif/cap_src.sv
// Far-side event source: capture pins and CAN receive pulses
`timescale 1ns/1ps
////////////////
module cap_src (
	input wire sys_clk_in, // Clock
	output reg std_pin_out, // Standard pin level
	output reg enh_pin_out, // Enhanced pin level
	output reg can_rx_out // Message received pulse
);
	// Pins idle low as inputs
	initial begin
		std_pin_out = 1'b0;
		enh_pin_out = 1'b0;
		can_rx_out = 1'b0;
	end
	// Event train: sel bit0 std pin, bit1 enh pin, bit2 CAN
	task automatic pulse(input [2:0] sel, input integer cnt);
		integer p;
		for (p = 0; p < cnt; p++) begin
			std_pin_out <= sel[0];
			enh_pin_out <= sel[1];
			can_rx_out <= sel[2];
			@(posedge sys_clk_in);
			can_rx_out <= 1'b0; // One cycle per message
			repeat (3) @(posedge sys_clk_in);
			std_pin_out <= 1'b0;
			enh_pin_out <= 1'b0;
			repeat (4) @(posedge sys_clk_in);
		end
	endtask
endmodule

// ### verif/capture_timer_timestamp_unit_assertions.sv
// Port-level checks for the capture timer timestamp unit
`timescale 1ns/1ps
////////////////
module cap_chk #(
	parameter PS_W = 4
) (
	input wire sys_clk_in, // Clock
	input wire rst_in, // Reset
	input wire ce_in, // Enable
	input wire hsel_in, // Select
	input wire [1:0] htrans_in, // Type
	input wire hwrite_in, // Write
	input wire hready_in, // Bus ready
	input wire hreadyout_out, // Ready
	input wire [31:0] hrdata_out, // Read data
	input wire hresp_out, // Response
	input wire std_irq_out, // Std irq
	input wire enh_irq_out, // Enh irq
	input wire first_timer_reset_out, // Timer one reset
	input wire third_timer_reset_out, // Timer three reset
	input wire adc_start_out // Conversion start
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Transfers taken at this edge
	wire acc = hsel_in && htrans_in[1] && hready_in && hreadyout_out && ce_in;
	wire wr_acc = acc && hwrite_in;
	sequence rd_wait;
		!hreadyout_out ##1 hreadyout_out;
	endsequence
	////////////////
	chk_resp_okay: assert property (hresp_out == 1'b0)
		else $error("response not okay");
	chk_read_wait: assert property (acc && !hwrite_in |=> rd_wait)
		else $error("read wait wrong");
	chk_write_zero: assert property (wr_acc |=> hreadyout_out)
		else $error("write stalled");
	chk_ce_freeze: assert property (!ce_in |=> $stable({hrdata_out, hreadyout_out, std_irq_out}))
		else $error("state moved while frozen");
	chk_std_hold: assert property ($fell(std_irq_out) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("std irq dropped alone");
	chk_enh_hold: assert property ($fell(enh_irq_out) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("enh irq dropped alone");
	chk_first_pulse: assert property (first_timer_reset_out |=> !first_timer_reset_out)
		else $error("timer one reset too long");
	chk_third_pulse: assert property (third_timer_reset_out |=> !third_timer_reset_out)
		else $error("timer three reset too long");
	chk_adc_trig: assert property (adc_start_out |-> first_timer_reset_out || third_timer_reset_out)
		else $error("conversion without trigger");
	chk_adc_pulse: assert property (adc_start_out |=> !adc_start_out)
		else $error("conversion start too long");
endmodule
bind capture_timer_timestamp_unit cap_chk #(.PS_W(PS_W)) chk_u (.sys_clk_in, .rst_in, .ce_in,
	.hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .hrdata_out, .hresp_out,
	.std_irq_out, .enh_irq_out, .first_timer_reset_out, .third_timer_reset_out, .adc_start_out);

// ### verif/tb.sv
// Self-checking bench for the capture timer timestamp unit
`timescale 1ns/1ps
////////////////
module tb;
	reg sys_clk_in, rst_in, ce_in, hsel_in, hwrite_in;
	reg [31:0] haddr_in, hwdata_in, rd;
	reg [1:0] htrans_in;
	reg [2:0] hsize_in;
	reg std_latch_in, std_drive_in, enh_latch_in, enh_drive_in;
	reg [15:0] first_timer_count_in, third_timer_count_in, c, t;
	reg [3:0] m, s;
	reg [39:0] rows [0:7];
	wire hready_in, std_pin_in, enh_pin_in, can_rx_pulse_in, hreadyout_out, hresp_out;
	wire std_irq_out, enh_irq_out, first_timer_reset_out, third_timer_reset_out, adc_start_out;
	wire [31:0] hrdata_out;
	integer bad_count, tests_run, i, j, k, n;
	assign hready_in = hreadyout_out;
	capture_timer_timestamp_unit #(.PS_W(4)) dut_u (.*);
	cap_src src_u (.sys_clk_in(sys_clk_in), .std_pin_out(std_pin_in),
		.enh_pin_out(enh_pin_in), .can_rx_out(can_rx_pulse_in));
	// Clock
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	////////////////
	task check(input string what, input [31:0] seen, input [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task wait_rdy;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n = n + 1;
		end while (hreadyout_out !== 1'b1 && n < 64);
		if (hreadyout_out !== 1'b1) begin
			bad_count = bad_count + 1;
			close_out;
		end
	endtask
	// One single word transfer
	task bus(input [7:0] a, input w, input [31:0] d);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		htrans_in <= 2'b10;
		hwrite_in <= w;
		wait_rdy;
		hsel_in <= 1'b0;
		htrans_in <= 2'b00;
		hwdata_in <= d;
		wait_rdy;
		rd = hrdata_out;
	endtask
	task rdchk(input string w, input [7:0] a, input [31:0] e);
		bus(a, 1'b0, 32'h0);
		check(w, rd, e);
	endtask
	////////////////
	initial begin
		{bad_count, tests_run, rst_in, ce_in} = {32'h0, 32'h0, 2'b11};
		{hsel_in, hwrite_in, haddr_in, hwdata_in, htrans_in, hsize_in} = {68'h0, 3'h2};
		{std_latch_in, std_drive_in, enh_latch_in, enh_drive_in} = 4'h0;
		{first_timer_count_in, third_timer_count_in} = 32'h0;
		// Mode, source, events, timer
		rows[0] = {4'h4, 4'h1, 16'h0001, 16'h1a2b};
		rows[1] = {4'h5, 4'h1, 16'h0001, 16'h2b3c};
		rows[2] = {4'h6, 4'h1, 16'h0004, 16'h3c4d};
		rows[3] = {4'h7, 4'h1, 16'h0010, 16'hffff};
		rows[4] = {4'h4, 4'h4, 16'h0001, 16'h0001};
		rows[5] = {4'h5, 4'h4, 16'h0001, 16'h8000};
		rows[6] = {4'h6, 4'h4, 16'h0004, 16'h5e6f};
		rows[7] = {4'h7, 4'h4, 16'h0010, 16'h7f80};
		repeat (20) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		rdchk("ctrl reset", 8'h00, 32'h0);
		rdchk("flag reset", 8'h14, 32'h0);
		rdchk("unmapped", 8'h30, 32'h0);
		for (i = 0; i < 8; i++) begin
			{m, s, c, t} = rows[i];
			first_timer_count_in <= t; // Timer counts move on the clock edge
			bus(8'h20, 1'b1, {27'h0, s[2], 4'h0});
			bus(8'h00, 1'b1, 32'h0);
			bus(8'h14, 1'b1, 32'h0);
			bus(8'h00, 1'b1, {28'h0, m});
			src_u.pulse(s[2:0], c - 1);
			rdchk("early flag", 8'h14, 32'h0);
			src_u.pulse(s[2:0], 1);
			rdchk("flag", 8'h14, 32'h4);
			rdchk("value", 8'h08, {16'h0, t});
		end
		// Newer capture replaces older
		bus(8'h20, 1'b1, 32'h0);
		bus(8'h00, 1'b1, 32'h5);
		src_u.pulse(3'h1, 1);
		first_timer_count_in <= 16'hbeef;
		src_u.pulse(3'h1, 1);
		rdchk("newer value", 8'h08, 32'hbeef);
		// Port write on a driven pin
		bus(8'h14, 1'b1, 32'h0);
		std_drive_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		std_latch_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		rdchk("port write flag", 8'h14, 32'h4);
		std_latch_in <= 1'b0;
		std_drive_in <= 1'b0;
		// Interrupt follows flag and enable
		bus(8'h1c, 1'b1, 32'h1);
		repeat (2) @(posedge sys_clk_in);
		check("irq set", {31'h0, std_irq_out}, 32'h1);
		bus(8'h14, 1'b1, 32'h0);
		repeat (2) @(posedge sys_clk_in);
		check("irq clear", {31'h0, std_irq_out}, 32'h0);
		// Direct prescaler switch keeps count
		bus(8'h00, 1'b1, 32'h0);
		bus(8'h00, 1'b1, 32'h7);
		src_u.pulse(3'h1, 5);
		bus(8'h00, 1'b1, 32'h6);
		src_u.pulse(3'h1, 1);
		rdchk("partial count", 8'h14, 32'h4);
		// Turning off clears count
		bus(8'h14, 1'b1, 32'h0);
		bus(8'h00, 1'b1, 32'h6);
		src_u.pulse(3'h1, 2);
		bus(8'h00, 1'b1, 32'h0);
		bus(8'h00, 1'b1, 32'h6);
		src_u.pulse(3'h1, 3);
		rdchk("cleared count", 8'h14, 32'h0);
		// Separate time bases per unit
		first_timer_count_in <= 16'h1111;
		third_timer_count_in <= 16'h3333;
		bus(8'h10, 1'b1, 32'h8);
		bus(8'h00, 1'b1, 32'h5);
		bus(8'h04, 1'b1, 32'h5);
		src_u.pulse(3'h3, 1);
		rdchk("std third", 8'h08, 32'h3333);
		rdchk("enh first", 8'h0c, 32'h1111);
		rdchk("enh flag", 8'h18, 32'h1);
		rdchk("timebase", 8'h24, 32'h7);
		// Special event trigger on enhanced unit
		bus(8'h10, 1'b1, 32'h0);
		bus(8'h0c, 1'b1, 32'h0077);
		first_timer_count_in <= 16'h0;
		bus(8'h04, 1'b1, 32'hb);
		first_timer_count_in <= 16'h0077;
		{j, k} = 64'h0;
		for (i = 0; i < 12; i++) begin
			@(posedge sys_clk_in);
			j = j + (first_timer_reset_out === 1'b1);
			k = k + (adc_start_out === 1'b1);
		end
		check("timer reset pulses", j, 32'h1);
		check("conversion pulses", k, 32'h1);
		// Enhanced interrupt follows its flag and enable
		bus(8'h1c, 1'b1, 32'h2);
		repeat (2) @(posedge sys_clk_in);
		check("enh irq set", {31'h0, enh_irq_out}, 32'h1);
		bus(8'h18, 1'b1, 32'h0);
		repeat (2) @(posedge sys_clk_in);
		check("enh irq clear", {31'h0, enh_irq_out}, 32'h0);
		// Trigger follows the enhanced unit onto the third timer
		bus(8'h10, 1'b1, 32'h40);
		@(posedge sys_clk_in);
		third_timer_count_in <= 16'h0077;
		{j, k} = 64'h0;
		for (i = 0; i < 12; i++) begin
			@(posedge sys_clk_in);
			j = j + (third_timer_reset_out === 1'b1);
			k = k + (first_timer_reset_out === 1'b1);
		end
		check("third reset pulses", j, 32'h1);
		check("first reset idle", k, 32'h0);
		// PWM units report the second timer
		bus(8'h00, 1'b1, 32'hc);
		rdchk("std pwm base", 8'h24, 32'he);
		bus(8'h04, 1'b1, 32'hc);
		rdchk("both pwm base", 8'h24, 32'ha);
		ce_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		ce_in <= 1'b1;
		close_out;
	end
endmodule

// ### verilog/capture_channel.v
// One capture/compare unit: pin sync, edge detect, prescaler, compare match
`timescale 1ns/1ps
`include "capture_consts.vh"

module capture_channel #(
	parameter PS_W = 4
) (
	input wire sys_clk_in, // System clock
	input wire rst_in, // Async reset, active high
	input wire ce_in, // Clock enable
	input wire pad_in, // Raw capture pin level
	input wire latch_in, // Port output latch level
	input wire drive_in, // High while pin is an output
	input wire can_sel_in, // CAN receive replaces pin
	input wire can_rx_in, // CAN message received pulse
	input wire [3:0] mode_in, // Unit mode field
	input wire [15:0] timer_in, // Selected timer count
	input wire [15:0] value_in, // Value pair for compare
	output wire capture_out, // Capture event pulse
	output wire match_out, // Compare match pulse
	output wire trigger_out // Special event trigger pulse
);

reg pad_s1_q;
reg pad_s2_q;
reg level_q;
reg match_q;
reg [PS_W-1:0] ps_cnt_q;
reg [PS_W-1:0] ps_cnt_d;
wire level;
wire rise;
wire fall;
wire is_capture;
wire is_compare;
wire event_hit;
wire ps_full;
wire match_now;

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser and edge detect

// Two flops before any logic reads the pad
always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		pad_s1_q <= 1'b0;
		pad_s2_q <= 1'b0;
		level_q <= 1'b0;
	end else if (ce_in) begin
		pad_s1_q <= pad_in;
		pad_s2_q <= pad_s1_q;
		level_q <= level;
	end
end

// A driven pin follows the latch, so a port write is an edge
assign level = drive_in ? latch_in : pad_s2_q;
assign rise = level & ~level_q;
assign fall = ~level & level_q;

////////////////////////////////////////////////////////////////////////////////
// Event select and prescaler

assign is_capture = (mode_in[3:2] == `CLASS_CAPTURE);
assign is_compare = (mode_in[3:2] == `CLASS_COMPARE);

// CAN receive pulse or the chosen pin edge
assign event_hit = ~is_capture ? 1'b0 :
	can_sel_in ? can_rx_in :
	(mode_in == `MODE_CAP_FALL) ? fall : rise;

// Terminal count; >= so a leftover count fires early
assign ps_full = (mode_in == `MODE_CAP_DIV4) ? (ps_cnt_q >= `PS_LAST_DIV4) :
	(mode_in == `MODE_CAP_DIV16) ? (ps_cnt_q >= `PS_LAST_DIV16) :
	1'b1;

// Counter clears outside capture, holds across prescaler change
always @* begin
	ps_cnt_d = ps_cnt_q;
	if (!is_capture) begin
		ps_cnt_d = {PS_W{1'b0}};
	end else if (event_hit) begin
		if (ps_full) begin
			ps_cnt_d = {PS_W{1'b0}};
		end else begin
			ps_cnt_d = ps_cnt_q + {{(PS_W-1){1'b0}}, 1'b1};
		end
	end
end

// Prescaler and compare edge flops
always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		ps_cnt_q <= {PS_W{1'b0}};
		match_q <= 1'b0;
	end else if (ce_in) begin
		ps_cnt_q <= ps_cnt_d;
		match_q <= match_now;
	end
end

assign capture_out = event_hit & ps_full;

////////////////////////////////////////////////////////////////////////////////
// Compare match, one pulse per match entry

assign match_now = is_compare & (timer_in == value_in);
assign match_out = match_now & ~match_q;
assign trigger_out = match_out & (mode_in == `MODE_CMP_TRIG);

endmodule

// ### verilog/capture_consts.vh
// Constants for the capture timer timestamp unit
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH

// Register byte offsets
`define OFS_STD_CTRL 8'h00
`define OFS_ENH_CTRL 8'h04
`define OFS_STD_VALUE 8'h08
`define OFS_ENH_VALUE 8'h0c
`define OFS_THIRD_TIMER_COUNT_CTRL 8'h10
`define OFS_FLAG_ONE 8'h14
`define OFS_FLAG_TWO 8'h18
`define OFS_INT_EN 8'h1c
`define OFS_CAN_IO 8'h20
`define OFS_STATUS 8'h24

// Field positions
`define BIT_STD_FLAG 2
`define BIT_ENH_FLAG 0
`define BIT_STD_IE 0
`define BIT_ENH_IE 1
`define BIT_CAN_TS 4
`define BIT_STD_USE_T3 3
`define BIT_ENH_USE_T3 6

// Reset values
`define RST_CTRL 6'h00
`define RST_VALUE 16'h0000
`define RST_BYTE 8'h00

// Mode field encodings
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_DIV4 4'h6
`define MODE_CAP_DIV16 4'h7
`define MODE_CMP_TRIG 4'hb
`define CLASS_CAPTURE 2'b01
`define CLASS_COMPARE 2'b10
`define CLASS_PWM 2'b11

// Prescaler terminal counts
`define PS_LAST_DIV4 4'h3
`define PS_LAST_DIV16 4'hf

// Timebase codes
`define TB_FIRST 2'h1
`define TB_SECOND 2'h2
`define TB_THIRD 2'h3

`endif

// ### verilog/capture_timer_timestamp_unit.v
// Two capture/compare units with timer select, flags and AHB-Lite registers
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "capture_consts.vh"

module capture_timer_timestamp_unit #(
	parameter PS_W = 4
) (
	input wire sys_clk_in, // System clock, 125 MHz
	input wire rst_in, // Async reset, active high
	input wire ce_in, // Clock enable, freezes all state
	input wire hsel_in, // AHB slave select
	input wire [31:0] haddr_in, // AHB address
	input wire [1:0] htrans_in, // AHB transfer type
	input wire hwrite_in, // AHB write
	input wire [2:0] hsize_in, // AHB size
	input wire [31:0] hwdata_in, // AHB write data
	input wire hready_in, // AHB bus ready
	output reg [31:0] hrdata_out, // AHB read data
	output reg hreadyout_out, // AHB slave ready
	output reg hresp_out, // AHB response, always OKAY
	input wire std_pin_in, // Standard unit capture pad
	input wire std_latch_in, // Standard pin port latch
	input wire std_drive_in, // Standard pin is an output
	input wire enh_pin_in, // Enhanced unit capture pad
	input wire enh_latch_in, // Enhanced pin port latch
	input wire enh_drive_in, // Enhanced pin is an output
	input wire can_rx_pulse_in, // CAN message received pulse
	input wire [15:0] first_timer_count_in, // First timer count
	input wire [15:0] third_timer_count_in, // Third timer count
	output reg std_irq_out, // Standard flag and enable
	output reg enh_irq_out, // Enhanced flag and enable
	output reg first_timer_reset_out, // Reset pulse to first timer
	output reg third_timer_reset_out, // Reset pulse to third timer
	output reg adc_start_out // Conversion start pulse
);

////////////////////////////////////////////////////////////////////////////////
// Register state

reg [5:0] std_ctrl_q;
reg [5:0] enh_ctrl_q;
reg [15:0] std_value_q;
reg [15:0] enh_value_q;
reg [7:0] third_timer_count_ctrl_q;
reg std_flag_q;
reg enh_flag_q;
reg std_ie_q;
reg enh_ie_q;
reg can_ts_q;

// Bus pipeline
reg wr_pend_q;
reg rd_pend_q;
reg [7:0] addr_q;
reg [31:0] rd_mux;

wire bus_take;
wire wr_now;
wire [3:0] std_mode;
wire [3:0] enh_mode;
wire std_t3;
wire enh_t3;
wire [15:0] std_timer;
wire [15:0] enh_timer;
wire [1:0] std_tb;
wire [1:0] enh_tb;
wire std_cap;
wire enh_cap;
wire std_match;
wire enh_match;
wire std_trig;
wire enh_trig;
wire std_set;
wire enh_set;

assign std_mode = std_ctrl_q[3:0];
assign enh_mode = enh_ctrl_q[3:0];

////////////////////////////////////////////////////////////////////////////////
// Timebase selection

// Select bits in the third timer control register
assign std_t3 = third_timer_count_ctrl_q[`BIT_STD_USE_T3];
assign enh_t3 = third_timer_count_ctrl_q[`BIT_ENH_USE_T3];

// Each unit picks on its own, sharing allowed
assign std_timer = std_t3 ? third_timer_count_in : first_timer_count_in;
assign enh_timer = enh_t3 ? third_timer_count_in : first_timer_count_in;

// PWM units report the second timer as their base
assign std_tb = (std_mode[3:2] == `CLASS_PWM) ? `TB_SECOND :
	std_t3 ? `TB_THIRD : `TB_FIRST;
assign enh_tb = (enh_mode[3:2] == `CLASS_PWM) ? `TB_SECOND :
	enh_t3 ? `TB_THIRD : `TB_FIRST;

////////////////////////////////////////////////////////////////////////////////
// Units

capture_channel #(
	.PS_W(PS_W)
) u_std (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.ce_in(ce_in),
	.pad_in(std_pin_in),
	.latch_in(std_latch_in),
	.drive_in(std_drive_in),
	.can_sel_in(can_ts_q),
	.can_rx_in(can_rx_pulse_in),
	.mode_in(std_mode),
	.timer_in(std_timer),
	.value_in(std_value_q),
	.capture_out(std_cap),
	.match_out(std_match),
	.trigger_out(std_trig)
);

capture_channel #(
	.PS_W(PS_W)
) u_enh (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.ce_in(ce_in),
	.pad_in(enh_pin_in),
	.latch_in(enh_latch_in),
	.drive_in(enh_drive_in),
	.can_sel_in(can_ts_q),
	.can_rx_in(can_rx_pulse_in),
	.mode_in(enh_mode),
	.timer_in(enh_timer),
	.value_in(enh_value_q),
	.capture_out(enh_cap),
	.match_out(enh_match),
	.trigger_out(enh_trig)
);

// Flag set sources
assign std_set = std_cap | std_match;
assign enh_set = enh_cap | enh_match;

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave

// Transfers of any size taken only while the slave is ready
assign bus_take = hsel_in & htrans_in[1] & hready_in & hreadyout_out;
assign wr_now = wr_pend_q;

// Bus phase tracking; reads take one wait state
always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		wr_pend_q <= 1'b0;
		rd_pend_q <= 1'b0;
		addr_q <= 8'h00;
		hreadyout_out <= 1'b1;
		hresp_out <= 1'b0;
		hrdata_out <= 32'h00000000;
	end else if (ce_in) begin
		hresp_out <= 1'b0;
		wr_pend_q <= bus_take & hwrite_in;
		rd_pend_q <= bus_take & ~hwrite_in;
		if (bus_take) begin
			addr_q <= {haddr_in[7:2], 2'b00};
		end
		if (bus_take & ~hwrite_in) begin
			hreadyout_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
		end
		if (rd_pend_q) begin
			hrdata_out <= rd_mux;
		end
	end
end

// Read data mux, unmapped reads zero
always @* begin
	rd_mux = 32'h00000000;
	case (addr_q)
		`OFS_STD_CTRL: rd_mux[5:0] = std_ctrl_q;
		`OFS_ENH_CTRL: rd_mux[5:0] = enh_ctrl_q;
		`OFS_STD_VALUE: rd_mux[15:0] = std_value_q;
		`OFS_ENH_VALUE: rd_mux[15:0] = enh_value_q;
		`OFS_THIRD_TIMER_COUNT_CTRL: rd_mux[7:0] = third_timer_count_ctrl_q;
		`OFS_FLAG_ONE: rd_mux[`BIT_STD_FLAG] = std_flag_q;
		`OFS_FLAG_TWO: rd_mux[`BIT_ENH_FLAG] = enh_flag_q;
		`OFS_INT_EN: rd_mux[1:0] = {enh_ie_q, std_ie_q};
		`OFS_CAN_IO: rd_mux[`BIT_CAN_TS] = can_ts_q;
		`OFS_STATUS: rd_mux[3:0] = {enh_tb, std_tb};
		default: rd_mux = 32'h00000000;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Control and configuration registers

always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		std_ctrl_q <= `RST_CTRL;
		enh_ctrl_q <= `RST_CTRL;
		third_timer_count_ctrl_q <= `RST_BYTE;
		std_ie_q <= 1'b0;
		enh_ie_q <= 1'b0;
		can_ts_q <= 1'b0;
	end else if (ce_in && wr_now) begin
		case (addr_q)
			// Mode 0000 turns the unit off and clears its prescaler count
			`OFS_STD_CTRL: std_ctrl_q <= hwdata_in[5:0];
			`OFS_ENH_CTRL: enh_ctrl_q <= hwdata_in[5:0];
			`OFS_THIRD_TIMER_COUNT_CTRL: third_timer_count_ctrl_q <= hwdata_in[7:0];
			`OFS_INT_EN: begin
				std_ie_q <= hwdata_in[`BIT_STD_IE];
				enh_ie_q <= hwdata_in[`BIT_ENH_IE];
			end
			`OFS_CAN_IO: can_ts_q <= hwdata_in[`BIT_CAN_TS];
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Value pairs: capture beats a same-cycle software write

always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		std_value_q <= `RST_VALUE;
		enh_value_q <= `RST_VALUE;
	end else if (ce_in) begin
		if (std_cap) begin
			std_value_q <= std_timer;
		end else if (wr_now && addr_q == `OFS_STD_VALUE) begin
			std_value_q <= hwdata_in[15:0];
		end
		if (enh_cap) begin
			enh_value_q <= enh_timer;
		end else if (wr_now && addr_q == `OFS_ENH_VALUE) begin
			enh_value_q <= hwdata_in[15:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sticky event flags, set wins over software clear

always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		std_flag_q <= 1'b0;
		enh_flag_q <= 1'b0;
	end else if (ce_in) begin
		if (std_set) begin
			std_flag_q <= 1'b1;
		end else if (wr_now && addr_q == `OFS_FLAG_ONE) begin
			std_flag_q <= hwdata_in[`BIT_STD_FLAG];
		end
		if (enh_set) begin
			enh_flag_q <= 1'b1;
		end else if (wr_now && addr_q == `OFS_FLAG_TWO) begin
			enh_flag_q <= hwdata_in[`BIT_ENH_FLAG];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs: interrupt levels and trigger pulses

always @(posedge sys_clk_in or posedge rst_in) begin
	if (rst_in) begin
		std_irq_out <= 1'b0;
		enh_irq_out <= 1'b0;
		first_timer_reset_out <= 1'b0;
		third_timer_reset_out <= 1'b0;
		adc_start_out <= 1'b0;
	end else if (ce_in) begin
		// Masking the enable hides a false flag on mode change
		std_irq_out <= std_flag_q & std_ie_q;
		enh_irq_out <= enh_flag_q & enh_ie_q;
		// Either trigger resets its own base, shared or not
		first_timer_reset_out <= (std_trig & ~std_t3) | (enh_trig & ~enh_t3);
		third_timer_reset_out <= (std_trig & std_t3) | (enh_trig & enh_t3);
		adc_start_out <= enh_trig;
	end
end

endmodule
